// *** hdl/framer_setup_pkg.sv ***
package framer_setup_pkg;

	// -----------------------------------------------------------------
	// Register byte offsets (all chosen, one aligned word each; OFS_TX_SIG0 and OFS_RX_SIG0 start twelve-word blocks)
	// -----------------------------------------------------------------
	localparam logic [7:0] OFS_LINE_CFG   = 8'h00;
	localparam logic [7:0] OFS_LOS_CFG    = 8'h04;
	localparam logic [7:0] OFS_FRAME_CFG  = 8'h08;
	localparam logic [7:0] OFS_HDLC_CFG   = 8'h0C;
	localparam logic [7:0] OFS_SIG_CFG    = 8'h10;
	localparam logic [7:0] OFS_COMMAND    = 8'h14;
	localparam logic [7:0] OFS_STATUS     = 8'h18;
	localparam logic [7:0] OFS_EVENTS     = 8'h1C;
	localparam logic [7:0] OFS_TX_SIG0    = 8'h20;
	localparam logic [7:0] OFS_RX_SIG0    = 8'h50;
	localparam int         SIG_REGS       = 12;

	// -----------------------------------------------------------------
	// Field positions
	// -----------------------------------------------------------------
	// Line config
	localparam int F_TX_CODE      = 0;   // 0 AMI+bit7 stuffing, 1 B8ZS
	localparam int F_RX_CODE      = 1;
	localparam int F_DUAL_RAIL    = 2;
	localparam int F_T1_MODE      = 3;
	// Los config: [7:0] detect, [15:8] recover, [17:16] mode, [20:18] level
	localparam int F_LOS_REC_LSB  = 8;
	localparam int F_LOS_MODE_LSB = 16;
	localparam int F_RIL_LSB      = 18;
	// Frame config
	localparam int F_AUTO_RAI     = 0;
	localparam int F_JAPAN        = 1;
	localparam int F_TX_RAI       = 2;
	localparam int F_AUTO_SYNC    = 3;
	localparam int F_RAF          = 4;
	localparam int F_REC_IRQ      = 5;
	// Signaling config
	localparam int F_BIT_ROB      = 0;
	localparam int F_SIG_MODE     = 1;
	localparam int F_CASE_MASK    = 2;
	localparam int F_RSC_MASK     = 3;
	// Hdlc config: [7:0] mode, [15:8] cfg one, 16..18 masks, 19/20 slot24
	localparam int F_CFG1_LSB     = 8;
	localparam int F_RME_MASK     = 16;
	localparam int F_RPF_MASK     = 17;
	localparam int F_XPR_MASK     = 18;
	localparam int F_RX_SLOT24    = 19;
	localparam int F_TX_SLOT24    = 20;
	// Command
	localparam int F_TX_RESET     = 0;
	localparam int F_RX_RESET     = 1;

	// -----------------------------------------------------------------
	// Reset values and decoded modes
	// -----------------------------------------------------------------
	localparam logic [31:0] LINE_CFG_RST  = 32'h0000_0008;
	localparam logic [31:0] HDLC_CFG_RST  = 32'h0007_0000;
	localparam logic [31:0] SIG_CFG_RST   = 32'h0000_000C;
	localparam logic [7:0]  HDLC_MODE_RX  = 8'h88;
	localparam logic [7:0]  HDLC_CFG1_TS  = 8'h18;
	localparam logic [1:0]  LOS_MODE_DENS = 2'h1;
	localparam int          DENSITY_ZEROS = 15;
	localparam int          SLOT_HDLC     = 23;  // slot 24, counted from 0
	localparam int          SLOTS         = 24;
	localparam logic [7:0]  ALL_ONES      = 8'hFF;
	localparam logic [7:0]  FLAG_BYTE     = 8'h7E;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

	// Dual-rail line symbol
	typedef struct packed {
		logic pos;
		logic neg;
	} rail_t;

	// Framer status seen by software
	typedef struct packed {
		logic los;
		logic frame_align_lost;
		logic rai_active;
		logic resync;
	} stat_t;

endpackage : framer_setup_pkg

// *** hdl/t1j1_line_framer_setup.sv ***
// Function
// - Analog line codes AMI with bit-7 stuffing and B8ZS, per direction; code encodes transmit only, receive code bit only shows in status.
// - Digital dual or single rail lines support the same two codes.
// - Detect count 0x0A declares loss of signal after 176 zeros.
// - Recover count 0x15 clears loss after 22 ones in the detect interval.
// - Recovery mode 01 also needs no more than 15 consecutive zeros.
// - Input level threshold 0x03 sets the loss amplitude threshold.
// - Recovery enable adds events when alarms clear, not just when set.
// - Auto remote alarm with lost alignment sends remote alarm.
// - Auto remote alarm stops once alignment returns.
// - Japan variant sends all-ones on the data link for remote alarm.
// - Japan select 0 gives CRC6 without framing and link bits.
// - Japan select 1 gives CRC6 with them, and japan remote alarm.
// - Auto sync starts resync on a frame search condition.
// - Mode 88h enables the receiver, accepting all frames.
// - Config one 18h puts signaling in slots with flag fill.
// - Hdlc end, pool full, pool ready requests only when unmasked.
// - Slot-select bit 0 set carries hdlc data in time slot 24.
// - Bit robbing plus signaling mode sends the twelve tx signaling regs.
// - Unmasked interrupts for tx signaling access and rx signaling change.
//
// Design decisions made here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
module t1j1_line_framer_setup (
	// Clock and reset
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	// AXI4-Lite write
	input  wire logic [7:0]              s_awaddr,
	input  wire logic                    s_awvalid,
	output logic                         s_awready,
	input  wire logic [31:0]             s_wdata,
	input  wire logic [3:0]              s_wstrb,
	input  wire logic                    s_wvalid,
	output logic                         s_wready,
	output logic [1:0]                   s_bresp,
	output logic                         s_bvalid,
	input  wire logic                    s_bready,
	// AXI4-Lite read
	input  wire logic [7:0]              s_araddr,
	input  wire logic                    s_arvalid,
	output logic                         s_arready,
	output logic [31:0]                  s_rdata,
	output logic [1:0]                   s_rresp,
	output logic                         s_rvalid,
	input  wire logic                    s_rready,
	// Line receive side (pins, asynchronous)
	input  wire framer_setup_pkg::rail_t rx_line,
	input  wire logic                    rx_level_ok,
	input  wire logic                    frame_align_lost,
	input  wire logic                    frame_search_flag,
	input  wire logic                    hdlc_rx_end,
	input  wire logic                    hdlc_rx_pool_full,
	input  wire logic                    hdlc_tx_pool_ready,
	input  wire logic [3:0]              rx_sig_bits,
	// Line transmit side and control outputs
	input  wire logic                    tx_bit,
	output framer_setup_pkg::rail_t      tx_line,
	output logic                         tx_single,
	output logic [2:0]                   rx_input_level_thresh,
	output logic                         crc6_with_fs_dl,
	output logic                         resync_start,
	output logic                         hdlc_rx_enable,
	output logic                         hdlc_flag_fill,
	output logic                         irq_request
);

	// -----------------------------------------------------------------
	// Registers and synchronisers
	// -----------------------------------------------------------------
	logic [31:0] line_cfg_r, los_cfg_r, frame_cfg_r, hdlc_cfg_r, sig_cfg_r;
	logic [31:0] events_r, events_nxt;
	localparam int SIG_REGS_L = framer_setup_pkg::SIG_REGS;
	logic [3:0]  tx_sig_r [SIG_REGS_L];
	logic [3:0]  rx_sig_r [SIG_REGS_L];
	logic [12:0] sync1_r, sync2_r;
	logic [7:0]  zero_run_r, ones_cnt_r, win_cnt_r;
	logic        los_r, rai_r, lfa_d_r, frame_search_flag_d_r;
	logic [4:0]  slot_r;
	logic [3:0]  sig_idx_r;
	logic [2:0]  b8zs_cnt_r;
	logic        last_mark_neg_r;
	logic [7:0]  tx_zero_r;

	// Two-flop capture of every pin-side input
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else begin
			sync1_r <= {rx_line, rx_level_ok, frame_align_lost, frame_search_flag, hdlc_rx_end,
				hdlc_rx_pool_full, hdlc_tx_pool_ready, rx_sig_bits, tx_bit};
			sync2_r <= sync1_r;
		end
	end

	wire       s_pos    = sync2_r[12];
	wire       s_neg    = sync2_r[11];
	wire       s_lvl    = sync2_r[10];
	wire       s_lfa    = sync2_r[9];
	wire       s_frame_search_flag   = sync2_r[8];
	wire       s_rme    = sync2_r[7];
	wire       s_rpf    = sync2_r[6];
	wire       s_xpr    = sync2_r[5];
	wire [3:0] s_rxsig  = sync2_r[4:1];
	wire       s_txbit  = sync2_r[0];

	// -----------------------------------------------------------------
	// Loss-of-signal detect and recovery
	// -----------------------------------------------------------------
	// Detect count N means (N+1)*16 zeros, so 0x0A gives 176; recover
	// count M means M+1 ones, so 0x15 gives 22 in the same window.
	wire [7:0]  los_det  = los_cfg_r[7:0];
	localparam int F_REC_HI = framer_setup_pkg::F_LOS_REC_LSB + 7;
	wire [7:0]  los_rec  = los_cfg_r[F_REC_HI:framer_setup_pkg::F_LOS_REC_LSB];
	wire [1:0]  los_mode = los_cfg_r[framer_setup_pkg::F_LOS_MODE_LSB +: 2];
	wire        rx_mark  = (s_pos | s_neg) & s_lvl;
	wire [11:0] det_len  = {los_det, 4'h0} + 12'h010;
	wire        det_hit  = ({4'h0, zero_run_r} >= det_len) || (zero_run_r == 8'hFF);
	wire        rec_hit  = ones_cnt_r > los_rec;
	wire        dens_ok  = (los_mode != framer_setup_pkg::LOS_MODE_DENS) ||
		(zero_run_r <= 8'(framer_setup_pkg::DENSITY_ZEROS));
	wire        win_end  = {4'h0, win_cnt_r} >= det_len - 12'h001;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			zero_run_r <= '0;
			ones_cnt_r <= '0;
			win_cnt_r  <= '0;
			los_r      <= 1'b0;
		end else begin
			zero_run_r <= rx_mark ? 8'h00 : (zero_run_r == 8'hFF ? zero_run_r : zero_run_r + 8'h01);
			win_cnt_r  <= win_end ? 8'h00 : win_cnt_r + 8'h01;
			ones_cnt_r <= win_end ? 8'h00 : (rx_mark && ones_cnt_r != 8'hFF ? ones_cnt_r + 8'h01 : ones_cnt_r);
			if (!los_r && det_hit)
				los_r <= 1'b1;
			else if (los_r && rec_hit && dens_ok)
				los_r <= 1'b0;
		end
	end
	assign rx_input_level_thresh = los_cfg_r[framer_setup_pkg::F_RIL_LSB +: 3];

	// -----------------------------------------------------------------
	// Framer: remote alarm, CRC6 scope, resync
	// -----------------------------------------------------------------
	wire japan     = frame_cfg_r[framer_setup_pkg::F_JAPAN];
	wire rai_want  = frame_cfg_r[framer_setup_pkg::F_TX_RAI] |
		(frame_cfg_r[framer_setup_pkg::F_AUTO_RAI] & s_lfa);
	wire rise_lfa  = s_lfa & ~lfa_d_r;
	wire fall_lfa  = ~s_lfa & lfa_d_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rai_r        <= 1'b0;
			lfa_d_r      <= 1'b0;
			frame_search_flag_d_r     <= 1'b0;
			resync_start <= 1'b0;
		end else begin
			rai_r        <= rai_want;
			lfa_d_r      <= s_lfa;
			frame_search_flag_d_r     <= s_frame_search_flag;
			resync_start <= frame_cfg_r[framer_setup_pkg::F_AUTO_SYNC] & s_frame_search_flag & ~frame_search_flag_d_r;
		end
	end
	assign crc6_with_fs_dl = japan;

	// -----------------------------------------------------------------
	// Slot counter and transmit data selection
	// -----------------------------------------------------------------
	wire [7:0] hdlc_mode  = hdlc_cfg_r[7:0];
	wire [7:0] hdlc_cfg1  = hdlc_cfg_r[framer_setup_pkg::F_CFG1_LSB +: 8];
	wire       slot_hdlc  = slot_r == 5'(framer_setup_pkg::SLOT_HDLC);
	wire       tx_hdlc_ts = slot_hdlc & hdlc_cfg_r[framer_setup_pkg::F_TX_SLOT24];
	wire       rob_on     = sig_cfg_r[framer_setup_pkg::F_BIT_ROB] & sig_cfg_r[framer_setup_pkg::F_SIG_MODE];
	wire       tx_data    = (japan & rai_r & slot_hdlc) ? 1'b1 :
		rob_on ? tx_sig_r[sig_idx_r][0] :
		tx_hdlc_ts ? (hdlc_flag_fill ? framer_setup_pkg::FLAG_BYTE[slot_r[2:0]] : s_txbit) :
		(rai_r ? 1'b0 : s_txbit);
	assign hdlc_rx_enable = (hdlc_mode == framer_setup_pkg::HDLC_MODE_RX) &
		hdlc_cfg_r[framer_setup_pkg::F_RX_SLOT24] & slot_hdlc;
	assign hdlc_flag_fill = hdlc_cfg1 == framer_setup_pkg::HDLC_CFG1_TS;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			slot_r    <= '0;
			sig_idx_r <= '0;
		end else begin
			slot_r    <= (slot_r == 5'(framer_setup_pkg::SLOTS - 1)) ? 5'h00 : slot_r + 5'h01;
			if (slot_r == 5'(framer_setup_pkg::SLOTS - 1))
				sig_idx_r <= (sig_idx_r == 4'(SIG_REGS_L - 1)) ? 4'h0 : sig_idx_r + 4'h1;
		end
	end

	// -----------------------------------------------------------------
	// Line encoder: AMI with bit-7 stuffing or B8ZS
	// -----------------------------------------------------------------
	// Simplified per-bit encoder: B8ZS replaces a run of eight zeros by
	// a violation, AMI forces a mark after six zeros.
	wire b8zs_tx   = line_cfg_r[framer_setup_pkg::F_TX_CODE];
	wire stuff_one = ~b8zs_tx & ~tx_data & (tx_zero_r == 8'd6);
	wire b8zs_viol = b8zs_tx & ~tx_data & (tx_zero_r == 8'd7);
	wire mark      = tx_data | stuff_one | b8zs_viol;
	wire pol_neg   = b8zs_viol ? last_mark_neg_r : ~last_mark_neg_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_zero_r       <= '0;
			last_mark_neg_r <= 1'b0;
			tx_line         <= '0;
			tx_single       <= 1'b0;
			b8zs_cnt_r      <= '0;
		end else begin
			tx_zero_r       <= mark ? 8'h00 : tx_zero_r + 8'h01;
			if (mark)
				last_mark_neg_r <= pol_neg;
			tx_line.pos     <= mark & ~pol_neg;
			tx_line.neg     <= line_cfg_r[framer_setup_pkg::F_DUAL_RAIL] ? (mark & pol_neg) : 1'b0;
			tx_single       <= mark;
			b8zs_cnt_r      <= b8zs_viol ? b8zs_cnt_r + 3'h1 : b8zs_cnt_r;
		end
	end

	// -----------------------------------------------------------------
	// Received signaling capture
	// -----------------------------------------------------------------
	wire rx_sig_chg = rob_on && (slot_r == 5'h00) && (rx_sig_r[sig_idx_r] != s_rxsig);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < SIG_REGS_L; i++)
				rx_sig_r[i] <= 4'h0;
		end else if (rx_sig_chg) begin
			rx_sig_r[sig_idx_r] <= s_rxsig;
		end
	end

	// -----------------------------------------------------------------
	// Sticky events: bit0 los set, 1 los clear, 2 lfa set, 3 lfa clear,
	// 4 rx end, 5 pool full, 6 pool ready, 7 tx sig access, 8 rx sig change
	// -----------------------------------------------------------------
	wire rec_irq  = frame_cfg_r[framer_setup_pkg::F_REC_IRQ];
	wire los_set  = ~los_r & det_hit;
	wire los_clr  = los_r & rec_hit & dens_ok;
	logic tx_sig_acc;
	logic [31:0] ev_set;
	assign ev_set = {23'h0, rx_sig_chg, tx_sig_acc, s_xpr, s_rpf, s_rme,
		fall_lfa & rec_irq, rise_lfa, los_clr & rec_irq, los_set};

	// Masks: 0 lets the request through
	wire [8:0] ev_mask = {sig_cfg_r[framer_setup_pkg::F_RSC_MASK], sig_cfg_r[framer_setup_pkg::F_CASE_MASK],
		hdlc_cfg_r[framer_setup_pkg::F_XPR_MASK], hdlc_cfg_r[framer_setup_pkg::F_RPF_MASK],
		hdlc_cfg_r[framer_setup_pkg::F_RME_MASK], 4'hF};
	assign irq_request = |(events_r[8:0] & ~ev_mask);

	// -----------------------------------------------------------------
	// AXI4-Lite slave
	// -----------------------------------------------------------------
	// Address and data latch separately so either may come first.
	logic        aw_hold_r, w_hold_r;
	logic [7:0]  aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0]  w_strb_r;
	assign s_awready = ~aw_hold_r & ~s_bvalid;
	assign s_wready  = ~w_hold_r & ~s_bvalid;
	assign s_arready = ~s_rvalid;
	wire   wr_go     = aw_hold_r & w_hold_r & ~s_bvalid;
	wire   sig_hit_w = aw_addr_r >= framer_setup_pkg::OFS_TX_SIG0 && aw_addr_r < framer_setup_pkg::OFS_RX_SIG0;
	wire [3:0] sig_w = 4'((aw_addr_r - framer_setup_pkg::OFS_TX_SIG0) >> 2);

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
		for (int b = 0; b < 4; b++)
			if (st[b])
				old[8*b +: 8] = nw[8*b +: 8];
		return old;
	endfunction : merge

	function automatic logic known(input logic [7:0] a);
		return a == framer_setup_pkg::OFS_LINE_CFG || a == framer_setup_pkg::OFS_LOS_CFG ||
			a == framer_setup_pkg::OFS_FRAME_CFG || a == framer_setup_pkg::OFS_HDLC_CFG ||
			a == framer_setup_pkg::OFS_SIG_CFG || a == framer_setup_pkg::OFS_COMMAND ||
			a == framer_setup_pkg::OFS_STATUS || a == framer_setup_pkg::OFS_EVENTS ||
			(a >= framer_setup_pkg::OFS_TX_SIG0 && a < 8'h80 && a[1:0] == 2'b00);
	endfunction : known

	// Write-one-to-clear on events; a fresh event wins over the clear
	wire ev_wr = wr_go && aw_addr_r == framer_setup_pkg::OFS_EVENTS;
	assign events_nxt = (events_r & ~(ev_wr ? merge(32'h0, w_data_r, w_strb_r) : 32'h0)) | ev_set;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_r <= 1'b0;
			w_hold_r  <= 1'b0;
			aw_addr_r <= '0;
			w_data_r  <= '0;
			w_strb_r  <= '0;
			s_bvalid  <= 1'b0;
			s_bresp   <= framer_setup_pkg::RESP_OKAY;
			line_cfg_r  <= framer_setup_pkg::LINE_CFG_RST;
			los_cfg_r   <= '0;
			frame_cfg_r <= '0;
			hdlc_cfg_r  <= framer_setup_pkg::HDLC_CFG_RST;
			sig_cfg_r   <= framer_setup_pkg::SIG_CFG_RST;
			events_r    <= '0;
			tx_sig_acc  <= 1'b0;
			for (int i = 0; i < SIG_REGS_L; i++)
				tx_sig_r[i] <= 4'h0;
		end else begin
			events_r   <= events_nxt;
			tx_sig_acc <= wr_go & sig_hit_w;
			if (s_awvalid && s_awready) begin
				aw_hold_r <= 1'b1;
				aw_addr_r <= s_awaddr;
			end
			if (s_wvalid && s_wready) begin
				w_hold_r <= 1'b1;
				w_data_r <= s_wdata;
				w_strb_r <= s_wstrb;
			end
			if (wr_go) begin
				aw_hold_r <= 1'b0;
				w_hold_r  <= 1'b0;
				s_bvalid  <= 1'b1;
				s_bresp   <= known(aw_addr_r) ? framer_setup_pkg::RESP_OKAY : framer_setup_pkg::RESP_SLVERR;
				case (aw_addr_r)
					framer_setup_pkg::OFS_LINE_CFG:  line_cfg_r  <= merge(line_cfg_r, w_data_r, w_strb_r);
					framer_setup_pkg::OFS_LOS_CFG:   los_cfg_r   <= merge(los_cfg_r, w_data_r, w_strb_r);
					framer_setup_pkg::OFS_FRAME_CFG: frame_cfg_r <= merge(frame_cfg_r, w_data_r, w_strb_r);
					framer_setup_pkg::OFS_HDLC_CFG:  hdlc_cfg_r  <= merge(hdlc_cfg_r, w_data_r, w_strb_r);
					framer_setup_pkg::OFS_SIG_CFG:   sig_cfg_r   <= merge(sig_cfg_r, w_data_r, w_strb_r);
					default: if (sig_hit_w && w_strb_r[0]) tx_sig_r[sig_w] <= w_data_r[3:0];
				endcase
			end else if (s_bvalid && s_bready) begin
				s_bvalid <= 1'b0;
			end
		end
	end

	// Read side: one cycle from address taken to data valid
	wire [3:0] sig_r_tx = 4'((s_araddr - framer_setup_pkg::OFS_TX_SIG0) >> 2);
	wire [3:0] sig_r_rx = 4'((s_araddr - framer_setup_pkg::OFS_RX_SIG0) >> 2);
	wire [31:0] rd_mux =
		s_araddr == framer_setup_pkg::OFS_LINE_CFG  ? line_cfg_r :
		s_araddr == framer_setup_pkg::OFS_LOS_CFG   ? los_cfg_r :
		s_araddr == framer_setup_pkg::OFS_FRAME_CFG ? frame_cfg_r :
		s_araddr == framer_setup_pkg::OFS_HDLC_CFG  ? hdlc_cfg_r :
		s_araddr == framer_setup_pkg::OFS_SIG_CFG   ? sig_cfg_r :
		s_araddr == framer_setup_pkg::OFS_STATUS    ? {24'h0, b8zs_cnt_r, line_cfg_r[framer_setup_pkg::F_RX_CODE],
			los_r, s_lfa, rai_r, resync_start} :
		s_araddr == framer_setup_pkg::OFS_EVENTS    ? events_r :
		(s_araddr >= framer_setup_pkg::OFS_RX_SIG0 && sig_r_rx < 4'(SIG_REGS_L)) ? {28'h0, rx_sig_r[sig_r_rx]} :
		(s_araddr >= framer_setup_pkg::OFS_TX_SIG0 && sig_r_tx < 4'(SIG_REGS_L)) ? {28'h0, tx_sig_r[sig_r_tx]} :
		32'h0000_0000;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_rvalid <= 1'b0;
			s_rdata  <= '0;
			s_rresp  <= framer_setup_pkg::RESP_OKAY;
		end else if (s_arvalid && s_arready) begin
			s_rvalid <= 1'b1;
			s_rdata  <= known(s_araddr) ? rd_mux : 32'h0000_0000;
			s_rresp  <= known(s_araddr) ? framer_setup_pkg::RESP_OKAY : framer_setup_pkg::RESP_SLVERR;
		end else if (s_rvalid && s_rready) begin
			s_rvalid <= 1'b0;
		end
	end

endmodule : t1j1_line_framer_setup

// *** tb/framer_setup_sva.sv ***
`timescale 1ns/1ps
module framer_setup_sva (
	// Clock and reset
	input wire logic                    aclk, aresetn,
	// Register bus
	input wire logic [7:0]              s_awaddr, s_araddr,
	input wire logic [31:0]             s_wdata, s_rdata,
	input wire logic [1:0]              s_rresp,
	input wire logic                    s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready,
	input wire logic                    s_arvalid, s_arready, s_rvalid,
	// Line and control
	input wire framer_setup_pkg::rail_t tx_line,
	input wire logic [2:0]              rx_input_level_thresh,
	input wire logic                    crc6_with_fs_dl, resync_start, hdlc_rx_enable, hdlc_flag_fill, irq_request
);
	// Shadow config; address and data are always offered together
	logic [31:0] line_r, los_r, frm_r, hdlc_r, sig_r;
	wire         wr_go = s_awvalid && s_awready && s_wvalid && s_wready;
	wire         rd_go = s_arvalid && s_arready;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			line_r <= framer_setup_pkg::LINE_CFG_RST;
			{los_r, frm_r} <= '0;
			hdlc_r <= framer_setup_pkg::HDLC_CFG_RST;
			sig_r <= framer_setup_pkg::SIG_CFG_RST;
		end else if (wr_go) begin
			case (s_awaddr)
				8'h00: line_r <= s_wdata;
				8'h04: los_r <= s_wdata;
				8'h08: frm_r <= s_wdata;
				8'h0C: hdlc_r <= s_wdata;
				8'h10: sig_r <= s_wdata;
				default: ;
			endcase
		end
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_b_stands: assert property (s_bvalid && !s_bready |=> s_bvalid) else $error("bvalid dropped");
	a_w_answer: assert property (wr_go |-> ##[1:2] s_bvalid) else $error("no write response");
	a_r_answer: assert property (rd_go |=> s_rvalid) else $error("late read data");
	a_unmapped_err: assert property (rd_go && s_araddr >= 8'h80 |=> s_rresp == 2'h2 && s_rdata == '0)
		else $error("unmapped read");
	a_ami_rails: assert property (!(tx_line.pos && tx_line.neg)) else $error("both rails");
	a_single_rail: assert property (s_bvalid && !line_r[2] |-> !tx_line.neg) else $error("neg rail");
	a_level_thresh: assert property (s_bvalid |-> rx_input_level_thresh == los_r[20:18])
		else $error("level threshold");
	a_crc_scope: assert property (s_bvalid |-> crc6_with_fs_dl == frm_r[1]) else $error("crc scope");
	a_resync_auto: assert property (resync_start |-> frm_r[3] ##1 !resync_start) else $error("resync");
	a_hdlc_mode: assert property (hdlc_rx_enable |-> $past(hdlc_r[7:0]) == 8'h88 && $past(hdlc_r[19]))
		else $error("mode");
	a_flag_fill: assert property (s_bvalid |-> hdlc_flag_fill == (hdlc_r[15:8] == 8'h18)) else $error("fill");
	a_irq_mask: assert property (s_bvalid && &hdlc_r[18:16] && &sig_r[3:2] |-> !irq_request)
		else $error("masked irq");
endmodule : framer_setup_sva
bind t1j1_line_framer_setup framer_setup_sva chk (.*);

// *** tb/line_terminal_model.sv ***
`timescale 1ns/1ps
module line_terminal_model (
	// Clock
	input wire logic                aclk,
	// Marks wanted, otherwise a dead line
	input wire logic                send_marks,
	// Received line towards the framer
	output framer_setup_pkg::rail_t rx_line
);
	// Marks alternate polarity so a healthy line never shows a bipolar violation
	logic pol_r = 1'b0;
	always_ff @(posedge aclk) begin
		pol_r <= pol_r ^ send_marks;
	end
	assign rx_line = send_marks ? (pol_r ? 2'b01 : 2'b10) : 2'b00;
endmodule : line_terminal_model

// *** tb/t1j1_line_framer_setup_test.sv ***
`timescale 1ns/1ps
module t1j1_line_framer_setup_test;
	// ---------------------------------------------------------------
	// Bench signals
	// ---------------------------------------------------------------
	logic        aclk = 0, aresetn = 0, marks = 1, aw, w, done;
	logic [7:0]  s_awaddr = '0, s_araddr = '0;
	logic [31:0] s_wdata = '0, rd;
	logic [1:0]  rp;
	logic        s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0, s_rready = 0;
	logic        frame_align_lost = 0, frame_search_flag = 0, hdlc_rx_end = 0, hdlc_rx_pool_full = 0;
	logic        hdlc_tx_pool_ready = 0;
	wire         s_awready, s_wready, s_bvalid, s_arready, s_rvalid, crc6_with_fs_dl, resync_start;
	wire         hdlc_rx_enable, hdlc_flag_fill, irq_request;
	wire [1:0]   s_bresp, s_rresp;
	wire [31:0]  s_rdata;
	wire [2:0]   rx_input_level_thresh;
	wire framer_setup_pkg::rail_t rx_line, tx_line;
	int          fail_count = 0, comparisons = 0;
	always #25 aclk = ~aclk;
	t1j1_line_framer_setup DUT (.*, .s_wstrb(4'hF), .rx_level_ok(1'b1), .tx_bit(1'b0), .rx_sig_bits(4'h0),
		.tx_single());
	line_terminal_model far (.aclk(aclk), .send_marks(marks), .rx_line(rx_line));
	// ---------------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------------
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("FAIL %0t %s", $time, what);
		end
	endtask : chk
	// Handshakes judged at the falling edge, acted on at the next rising edge
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		done = 0;
		@(posedge aclk);
		if (wr) {s_awaddr, s_wdata, s_awvalid, s_wvalid, s_bready} <= {a, d, 3'b111};
		else {s_araddr, s_arvalid, s_rready} <= {a, 2'b11};
		for (int n = 0; n < 40 && !done; n++) begin
			@(negedge aclk);
			aw = s_awvalid && s_awready;
			w = s_wvalid && s_wready;
			done = (s_bvalid && s_bready) || (s_rvalid && s_rready);
			{rd, rp} = wr ? {32'h0000_0000, s_bresp} : {s_rdata, s_rresp};
			@(posedge aclk);
			if (aw) s_awvalid <= 0;
			if (w) s_wvalid <= 0;
			if (s_arvalid && s_arready) s_arvalid <= 0;
			if (done) {s_bready, s_rready} <= 2'b00;
		end
		if (!done) begin
			fail_count++;
			give_verdict();
		end
	endtask : bus
	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_defaults();
		bus(0, framer_setup_pkg::OFS_HDLC_CFG, 0);
		chk(rd, framer_setup_pkg::HDLC_CFG_RST, "hdlc cfg reset");
		bus(0, framer_setup_pkg::OFS_SIG_CFG, 0);
		chk(rd, framer_setup_pkg::SIG_CFG_RST, "sig cfg reset");
		bus(0, 8'hFC, 0);
		chk(rp, framer_setup_pkg::RESP_SLVERR, "unmapped resp");
		$display("defaults done");
	endtask : t_defaults
	// Detect 0x0A gives 176 zeros, recover 0x15 needs 22 ones; reads sit well clear of both edges
	task automatic t_los();
		bus(1, framer_setup_pkg::OFS_LOS_CFG, 32'h000D_150A);
		chk(rx_input_level_thresh, 3'h3, "level threshold");
		bus(1, framer_setup_pkg::OFS_FRAME_CFG, 32'h0000_0020);
		bus(1, framer_setup_pkg::OFS_EVENTS, 32'h0000_01FF);
		marks <= 0;
		repeat (145) @(posedge aclk);
		bus(0, framer_setup_pkg::OFS_STATUS, 0);
		chk(rd[3], 1'b0, "loss too early");
		repeat (40) @(posedge aclk);
		bus(0, framer_setup_pkg::OFS_STATUS, 0);
		chk(rd[3], 1'b1, "loss not declared");
		marks <= 1;
		repeat (8) @(posedge aclk);
		bus(0, framer_setup_pkg::OFS_STATUS, 0);
		chk(rd[3], 1'b1, "loss cleared early");
		repeat (220) @(posedge aclk);
		bus(0, framer_setup_pkg::OFS_STATUS, 0);
		chk(rd[3], 1'b0, "loss not recovered");
		bus(0, framer_setup_pkg::OFS_EVENTS, 0);
		chk(rd[1:0], 2'b11, "loss events");
		$display("loss of signal done");
	endtask : t_los
	task automatic t_frame();
		bus(1, framer_setup_pkg::OFS_FRAME_CFG, 32'h0000_0001);
		frame_align_lost <= 1;
		repeat (6) @(posedge aclk);
		bus(0, framer_setup_pkg::OFS_STATUS, 0);
		chk(rd[1], 1'b1, "auto alarm off");
		frame_align_lost <= 0;
		repeat (6) @(posedge aclk);
		bus(0, framer_setup_pkg::OFS_STATUS, 0);
		chk(rd[1], 1'b0, "auto alarm stuck");
		bus(1, framer_setup_pkg::OFS_FRAME_CFG, 32'h0000_000A);
		chk(crc6_with_fs_dl, 1'b1, "crc with fs dl");
		frame_search_flag <= 1;
		done = 0;
		for (int n = 0; n < 10 && !done; n++) @(negedge aclk) done = resync_start;
		chk(done, 1'b1, "no resync");
		bus(1, framer_setup_pkg::OFS_FRAME_CFG, 32'h0000_0000);
		frame_search_flag <= 0;
		chk(crc6_with_fs_dl, 1'b0, "crc without fs dl");
		$display("framer done");
	endtask : t_frame
	task automatic t_hdlc();
		bus(1, framer_setup_pkg::OFS_HDLC_CFG, 32'h0018_1888);
		done = 0;
		repeat (24) @(negedge aclk) if (hdlc_rx_enable) done = 1;
		chk({done, hdlc_flag_fill}, 2'b11, "hdlc mode");
		bus(0, framer_setup_pkg::OFS_HDLC_CFG, 0);
		chk(rd[20:19], 2'b11, "slot 24 select");
		for (int i = 0; i < 6; i++) begin
			{hdlc_tx_pool_ready, hdlc_rx_pool_full, hdlc_rx_end} <= 3'(1 << i % 3);
			repeat (2) @(posedge aclk);
			{hdlc_tx_pool_ready, hdlc_rx_pool_full, hdlc_rx_end} <= 3'h0;
			repeat (4) @(negedge aclk);
			chk(irq_request, i < 3, "hdlc request");
			bus(1, framer_setup_pkg::OFS_EVENTS, 32'h0000_01FF);
			if (i == 2) bus(1, framer_setup_pkg::OFS_HDLC_CFG, 32'h0007_1888);
		end
		$display("hdlc done");
	endtask : t_hdlc
	task automatic t_sig();
		bus(1, framer_setup_pkg::OFS_SIG_CFG, 32'h0000_0003);
		bus(1, framer_setup_pkg::OFS_TX_SIG0 + 8'h2C, 32'h0000_0005);
		bus(0, framer_setup_pkg::OFS_TX_SIG0 + 8'h2C, 0);
		chk(rd[3:0], 4'h5, "last tx signaling reg");
		chk(irq_request, 1'b1, "signaling access irq");
		$display("signaling done");
	endtask : t_sig
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1;
		t_defaults();
		bus(1, framer_setup_pkg::OFS_LINE_CFG, 32'h0000_0008);
		t_los();
		t_frame();
		t_hdlc();
		t_sig();
		bus(1, framer_setup_pkg::OFS_COMMAND, 32'h0000_0003);
		give_verdict();
	end
endmodule : t1j1_line_framer_setup_test
